// >>> timer_map.svh
// Field positions, reset values and fixed figures of the timer block
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ==========================================================
// Start register layout
`define PWM_RUN_BIT       0
`define MEAS_RUN_LSB      5
`define MEAS_RUN_MSB      7
`define MEAS_COUNT        6
`define START_RST         8'h00
`define SECOND_START_MASK 8'he0

// ==========================================================
// Reset values and fixed counter values
`define MODE_RST          8'h00
`define CNT_RST           16'h0000
`define CNT_ONE           16'h0001
`define CNT_ALL_ONES      16'hffff
`define PWM_PERIOD_TOP    16'hffff

`endif

// >>> timer_pkg.sv
// Types shared by the timer block files
package timer_pkg;

  // ==========================================================
  // Operating mode field; OP_SPECIAL does not count on the PWM timer and is
  // pulse period/width measurement on the measurement timers
  typedef enum logic [1:0] {OP_TIMER, OP_EVENT, OP_SPECIAL, OP_PWM} op_mode_t;

  // ==========================================================
  // Mode register image, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] count_src_sel;
    logic       overflow_flag;
    logic       option_bit_two;
    logic       option_bit_one;
    logic       option_bit_zero;
    op_mode_t   op_mode_sel;
  } mode_reg_t;

  // ==========================================================
  // Counter register write
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } cnt_write_t;

endpackage

// >>> meas_timer.sv
// One measurement-group timer: timer, event counter and pulse measurement
`timescale 1ns/10ps
`include "timer_map.svh"

module meas_timer
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Control from start register and sources
  input  wire logic        run,
  input  wire logic [3:0]  src_tick,
  input  wire logic        pin_in,
  // Register writes
  input  wire logic        mode_wr,
  input  wire mode_reg_t   mode_wdata,
  input  wire logic        cnt_wr,
  input  wire logic [15:0] cnt_wdata,
  input  wire logic        irq_clr,
  // Read back and request
  output mode_reg_t        mode_rdata,
  output logic [15:0]      cnt_rdata,
  output logic             irq_flag
);

  mode_reg_t   mode_q;
  logic [15:0] cnt_q;
  logic [15:0] reload_q;
  logic [15:0] rdata_q;
  logic        ovf_q;
  logic        ovf_age_q;
  logic        first_q;
  logic        pin_q;
  logic        run_q;
  logic        irq_q;

  // ==========================================================
  // Decode of mode, source and edges
  wire logic tick     = src_tick[mode_q.count_src_sel];
  wire logic is_timer = (mode_q.op_mode_sel == OP_TIMER);
  wire logic is_event = (mode_q.op_mode_sel == OP_EVENT);
  wire logic is_meas  = (mode_q.op_mode_sel == OP_SPECIAL);
  wire logic rise     = pin_in & ~pin_q;
  wire logic fall     = ~pin_in & pin_q;
  wire logic start    = run & ~run_q;
  // Width mode takes both edges, so high and low widths alternate unlabelled
  wire logic meas_edge = mode_q.option_bit_one ? (rise | fall) :
                         (mode_q.option_bit_zero ? rise : fall);
  wire logic evt_edge  = mode_q.option_bit_zero ? rise : fall;

  // ==========================================================
  // Counting events
  wire logic dec_ev    = run & ((is_timer & tick) | (is_event & evt_edge));
  wire logic underflow = dec_ev & (cnt_q == `CNT_RST);
  wire logic edge_ev   = run & is_meas & meas_edge;
  // Counter starts undefined, so overflow may come before the first edge
  wire logic ovf_ev    = run & is_meas & tick & (cnt_q == `CNT_ALL_ONES);
  // Clear only from a running write after a tick has aged the flag
  wire logic ovf_clr   = mode_wr & run & ovf_q & ovf_age_q;
  wire logic irq_set   = underflow | (edge_ev & ~first_q) | ovf_ev;

  // ==========================================================
  // Next values
  wire logic [15:0] cnt_d =
    (cnt_wr & ~run)      ? cnt_wdata :
    underflow            ? reload_q :
    dec_ev               ? cnt_q - `CNT_ONE :
    edge_ev              ? `CNT_RST :
    (run & is_meas & tick) ? cnt_q + `CNT_ONE :
                           cnt_q;
  // First edge copies the undefined count without a request
  wire logic [15:0] reload_d =
    (cnt_wr & ~(run & is_meas)) ? cnt_wdata :
    edge_ev                     ? cnt_q :
                                  reload_q;
  // Reads never disturb the counter; a reload cycle reads all ones
  wire logic [15:0] rdata_d =
    underflow ? `CNT_ALL_ONES :
    is_meas   ? reload_q :
                cnt_q;
  wire logic ovf_d   = ovf_ev | (ovf_q & ~ovf_clr);
  wire logic age_d   = ovf_ev ? 1'b0 : ((ovf_q & tick) | ovf_age_q);
  wire logic first_d = start | (first_q & ~edge_ev);
  wire logic irq_d   = irq_set | (irq_q & ~irq_clr);

  // ==========================================================
  // State registers; mode writes while running only clear overflow
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mode_q    <= `MODE_RST;
      cnt_q     <= `CNT_RST;
      reload_q  <= `CNT_RST;
      rdata_q   <= `CNT_RST;
      ovf_q     <= 1'b0;
      ovf_age_q <= 1'b0;
      first_q   <= 1'b0;
      pin_q     <= 1'b0;
      run_q     <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      mode_q    <= (mode_wr & ~run) ? mode_wdata : mode_q;
      cnt_q     <= cnt_d;
      reload_q  <= reload_d;
      rdata_q   <= rdata_d;
      ovf_q     <= ovf_d;
      ovf_age_q <= age_d;
      first_q   <= first_d;
      pin_q     <= pin_in;
      run_q     <= run;
      irq_q     <= irq_d;
    end
  end

  // ==========================================================
  // Outputs; overflow bit is status, not the stored write value
  always_comb
  begin
    mode_rdata = mode_q;
    mode_rdata.overflow_flag = ovf_q;
  end
  assign cnt_rdata = rdata_q;
  assign irq_flag  = irq_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_meas_reload_ones: assert property (underflow |=> cnt_rdata == `CNT_ALL_ONES)
    else $error("reload cycle did not read all ones");
  a_stopped_count_hold: assert property ((!run && !cnt_wr) |=> cnt_q == $past(cnt_q))
    else $error("stopped counter moved");
  a_event_read_safe: assert property ((run && is_event && !evt_edge && !cnt_wr) |=> cnt_q == $past(cnt_q))
    else $error("event count changed without an edge");
  a_first_edge_quiet: assert property ((edge_ev && first_q && !ovf_ev && !underflow) |=>
      (reload_q == $past(cnt_q)) && (irq_q == ($past(irq_q) & ~$past(irq_clr))))
    else $error("first edge raised a request or lost the count");
  a_edge_requests: assert property ((edge_ev && !first_q) |=> irq_q && reload_q == $past(cnt_q))
    else $error("measured edge gave no request");
  a_ovf_sets_flag: assert property (ovf_ev |=> ovf_q && irq_q && cnt_q == `CNT_RST)
    else $error("overflow not flagged");
  a_ovf_clear_gate: assert property ($fell(ovf_q) |-> $past(mode_wr) && $past(run) && $past(ovf_age_q))
    else $error("overflow flag cleared without an aged running write");

  c_meas_edge: cover property (edge_ev && !first_q);
  c_meas_ovf_clear: cover property (ovf_clr);
endmodule

// >>> timer_pwm_and_pulse_measure.sv
// PWM timer and measurement timer group with their start registers
`timescale 1ns/10ps
`include "timer_map.svh"


module timer_pwm_and_pulse_measure
  import timer_pkg::*;
#(
  parameter logic [15:0] PWM_PERIOD_TOP = `PWM_PERIOD_TOP
)
(
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  // Count sources, one enable pulse per selectable source
  input  wire logic [3:0]                    src_tick,
  // Start registers
  input  wire logic                          shared_start_wr,
  input  wire logic [7:0]                    shared_start_wdata,
  input  wire logic                          second_start_wr,
  input  wire logic [7:0]                    second_start_wdata,
  output logic [7:0]                         shared_start_rdata,
  output logic [7:0]                         second_start_rdata,
  // PWM timer registers
  input  wire logic                          pwm_mode_wr,
  input  wire mode_reg_t                     pwm_mode_wdata,
  input  wire cnt_write_t                    pwm_cnt_write,
  input  wire logic                          pwm_irq_clr,
  output mode_reg_t                          pwm_timer_mode_rdata,
  output logic [15:0]                        pwm_timer_counter_rdata,
  output logic                               pwm_int_request_flag,
  // PWM timer pins
  input  wire logic                          pwm_event_in,
  output logic                               pwm_output_pin,
  // Measurement timer registers
  input  wire logic [`MEAS_COUNT-1:0]        meas_mode_wr,
  input  wire mode_reg_t                     meas_mode_wdata,
  input  wire logic [`MEAS_COUNT-1:0]        meas_cnt_wr,
  input  wire logic [15:0]                   meas_cnt_wdata,
  input  wire logic [`MEAS_COUNT-1:0]        meas_irq_clr,
  output mode_reg_t [`MEAS_COUNT-1:0]        meas_timer_mode_rdata,
  output logic [`MEAS_COUNT-1:0][15:0]       meas_timer_counter_rdata,
  output logic [`MEAS_COUNT-1:0]             meas_int_request_flag,
  // Measurement timer pins
  input  wire logic [`MEAS_COUNT-1:0]        meas_pin_in
);

  logic [7:0]  shared_q;
  logic [7:0]  second_q;
  mode_reg_t   pwm_mode_q;
  logic [15:0] pwm_cnt_q;
  logic [15:0] pwm_reload_q;
  logic [15:0] pwm_rdata_q;
  logic        pwm_out_q;
  logic        pwm_irq_q;
  logic        pwm_run_q;
  logic        pwm_ev_q;

  // ==========================================================
  // Run bits
  wire logic pwm_run = shared_q[`PWM_RUN_BIT];
  // Measurement timers 0-2 sit in the shared register, 3-5 in the second
  wire logic [`MEAS_COUNT-1:0] meas_run =
    {second_q[`MEAS_RUN_MSB:`MEAS_RUN_LSB], shared_q[`MEAS_RUN_MSB:`MEAS_RUN_LSB]};

  // ==========================================================
  // PWM timer decode
  wire logic pwm_tick  = src_tick[pwm_mode_q.count_src_sel];
  wire logic is_tmr    = (pwm_mode_q.op_mode_sel == OP_TIMER);
  wire logic is_evt    = (pwm_mode_q.op_mode_sel == OP_EVENT);
  wire logic is_pwm    = (pwm_mode_q.op_mode_sel == OP_PWM);
  wire logic pwm_start = pwm_run & ~pwm_run_q;
  wire logic pwm_stop  = ~pwm_run & pwm_run_q;
  wire logic evt_edge  = pwm_event_in & ~pwm_ev_q;

  // Nothing counts until the run bit is set; start cycle only loads the top, in PWM mode
  wire logic pwm_dec = pwm_run & ~pwm_start &
                       ((pwm_tick & (is_tmr | is_pwm)) | (is_evt & evt_edge));
  wire logic pwm_udf = pwm_dec & (pwm_cnt_q == `CNT_RST);

  // Mode writes are taken only while stopped, so a running timer cannot
  // be thrown into a half-configured mode
  wire logic pwm_mode_take  = pwm_mode_wr & ~pwm_run;
  // Reset mode is plain timer, so first PWM selection is covered too
  wire logic pwm_mode_entry = pwm_mode_take &
                              (pwm_mode_wdata.op_mode_sel == OP_PWM) & (is_tmr | is_evt);

  // ==========================================================
  // PWM counter: period counts down from the top; the width sits in reload
  wire logic [15:0] pwm_cnt_d =
    (pwm_cnt_write.wr & ~pwm_run) ? pwm_cnt_write.data :
    (pwm_start & is_pwm)          ? PWM_PERIOD_TOP :
    (pwm_udf & is_pwm)            ? PWM_PERIOD_TOP :
    pwm_udf                       ? pwm_reload_q :
    pwm_dec                       ? pwm_cnt_q - `CNT_ONE :
                                    pwm_cnt_q;
  wire logic [15:0] pwm_reload_d = pwm_cnt_write.wr ? pwm_cnt_write.data : pwm_reload_q;
  wire logic [15:0] elapsed_d    = PWM_PERIOD_TOP - pwm_cnt_d;

  // ==========================================================
  // PWM output: high for the first reload counts of each period.
  // Stop forces low; a pin already low simply stays low.
  wire logic pwm_out_d = pwm_run & is_pwm & (elapsed_d < pwm_reload_q);
  // Request on every falling output edge, including the one a stop makes
  wire logic pwm_fall  = pwm_out_q & ~pwm_out_d;
  wire logic pwm_set   = pwm_mode_entry | pwm_fall | (pwm_udf & ~is_pwm);
  // Set wins over a clear arriving in the same cycle
  wire logic pwm_irq_d = pwm_set | (pwm_irq_q & ~pwm_irq_clr);

  // Read back: all ones in a reload cycle outside PWM mode, else the live count
  wire logic [15:0] pwm_rdata_d = (pwm_udf & ~is_pwm) ? `CNT_ALL_ONES : pwm_cnt_q;

  // ==========================================================
  // Start registers; unused bits of the second one read as zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      shared_q <= `START_RST;
      second_q <= `START_RST;
    end
    else
    begin
      shared_q <= shared_start_wr ? shared_start_wdata : shared_q;
      second_q <= second_start_wr ? (second_start_wdata & `SECOND_START_MASK) : second_q;
    end
  end

  // ==========================================================
  // PWM timer registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pwm_mode_q   <= `MODE_RST;
      pwm_cnt_q    <= `CNT_RST;
      pwm_reload_q <= `CNT_RST;
      pwm_rdata_q  <= `CNT_RST;
      pwm_out_q    <= 1'b0;
      pwm_irq_q    <= 1'b0;
      pwm_run_q    <= 1'b0;
      pwm_ev_q     <= 1'b0;
    end
    else
    begin
      pwm_mode_q   <= pwm_mode_take ? pwm_mode_wdata : pwm_mode_q;
      pwm_cnt_q    <= pwm_cnt_d;
      pwm_reload_q <= pwm_reload_d;
      pwm_rdata_q  <= pwm_rdata_d;
      pwm_out_q    <= pwm_out_d;
      pwm_irq_q    <= pwm_irq_d;
      pwm_run_q    <= pwm_run;
      pwm_ev_q     <= pwm_event_in;
    end
  end

  // ==========================================================
  // Outputs
  assign shared_start_rdata      = shared_q;
  assign second_start_rdata      = second_q;
  assign pwm_timer_mode_rdata    = pwm_mode_q;
  assign pwm_timer_counter_rdata = pwm_rdata_q;
  assign pwm_int_request_flag    = pwm_irq_q;
  assign pwm_output_pin          = pwm_out_q;

  // ==========================================================
  // Measurement timer group
  for (genvar i = 0; i < `MEAS_COUNT; i++)
  begin : g_meas
    meas_timer u_meas (
      .clock      (clock),
      .rst_n      (rst_n),
      .run        (meas_run[i]),
      .src_tick   (src_tick),
      .pin_in     (meas_pin_in[i]),
      .mode_wr    (meas_mode_wr[i]),
      .mode_wdata (meas_mode_wdata),
      .cnt_wr     (meas_cnt_wr[i]),
      .cnt_wdata  (meas_cnt_wdata),
      .irq_clr    (meas_irq_clr[i]),
      .mode_rdata (meas_timer_mode_rdata[i]),
      .cnt_rdata  (meas_timer_counter_rdata[i]),
      .irq_flag   (meas_int_request_flag[i])
    );
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_idle_no_count: assert property ((!pwm_run && !pwm_cnt_write.wr) |=> pwm_cnt_q == $past(pwm_cnt_q))
    else $error("stopped PWM timer counted");
  a_pwm_entry_irq: assert property (pwm_mode_entry |=> pwm_irq_q && pwm_mode_q.op_mode_sel == OP_PWM)
    else $error("PWM mode entry gave no request");
  a_stop_high_low: assert property ((pwm_stop && pwm_out_q) |=> !pwm_out_q && pwm_irq_q)
    else $error("stop while high did not drive low with request");
  a_stop_low_hold: assert property ((pwm_stop && !pwm_out_q && !pwm_mode_wr) |=>
      !pwm_out_q && (pwm_irq_q == ($past(pwm_irq_q) & ~$past(pwm_irq_clr))))
    else $error("stop while low changed output or request");
  a_run_bit_low: assert property ((shared_start_wr && shared_start_wdata[5]) |=> meas_run[0])
    else $error("shared bit 5 did not start measurement timer 0");
  a_run_bit_high: assert property ((second_start_wr && second_start_wdata[7]) |=> meas_run[5])
    else $error("second bit 7 did not start measurement timer 5");
  a_pwm_reload_ones: assert property ((pwm_udf && !is_pwm) |=>
      pwm_timer_counter_rdata == `CNT_ALL_ONES && pwm_cnt_q == $past(pwm_reload_q))
    else $error("reload read or reload value wrong");
  a_pwm_readback: assert property ((!pwm_run && pwm_cnt_write.wr ##1 !pwm_run && !pwm_cnt_write.wr) |=>
      pwm_timer_counter_rdata == $past(pwm_cnt_write.data, 2))
    else $error("stopped counter did not read back written value");

  c_pwm_entry: cover property (pwm_mode_entry);
  c_stop_high: cover property (pwm_stop && pwm_out_q);
  c_pwm_cycle: cover property (pwm_run && is_pwm && pwm_fall);
endmodule

// >>> pulse_source.sv
// Model of an external pulse source that drives one timer input pin
`timescale 1ns/10ps

module pulse_source
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Burst shape and trigger
  input  wire logic       go,
  input  wire logic [7:0] high_len,
  input  wire logic [7:0] low_len,
  input  wire logic [3:0] count,
  // Pin
  output logic            pin
);
  logic [7:0] len_q;
  logic [3:0] left_q;

  // Low phase first, so each pulse opens with a rising edge; the pin rests low between bursts
  always @(negedge clock)
  begin
    if (!rst_n || left_q == 4'h0)
    begin
      pin    <= 1'h0;
      len_q  <= low_len;
      left_q <= (rst_n && go) ? count : 4'h0;
    end
    else if (len_q > 8'h01)
      len_q <= len_q - 8'h01;
    else
    begin
      pin    <= ~pin;
      len_q  <= pin ? low_len : high_len;
      left_q <= pin ? left_q - 4'h1 : left_q;
    end
  end
endmodule

// >>> timer_pwm_and_pulse_measure_bench.sv
// Self-checking bench for the PWM timer and the measurement timer group
`timescale 1ns/10ps

module timer_pwm_and_pulse_measure_bench;
  import timer_pkg::*;
  // Short PWM period keeps the waveform checks brief
  localparam logic [15:0] TOP = 16'h000f;
  logic                  clock, rst_n, shared_start_wr, second_start_wr, pwm_mode_wr, pwm_irq_clr;
  logic [3:0]            src_tick;
  logic [7:0]            shared_start_wdata, second_start_wdata, shared_start_rdata, second_start_rdata;
  mode_reg_t             pwm_mode_wdata, pwm_timer_mode_rdata, meas_mode_wdata;
  cnt_write_t            pwm_cnt_write;
  logic [15:0]           pwm_timer_counter_rdata, meas_cnt_wdata;
  logic                  pwm_int_request_flag, pwm_output_pin, src_pin, burst_go, pwm_event_in;
  logic [5:0]            meas_mode_wr, meas_cnt_wr, meas_irq_clr, meas_int_request_flag, meas_pin_in;
  mode_reg_t [5:0]       meas_timer_mode_rdata;
  logic [5:0][15:0]      meas_timer_counter_rdata;
  logic [7:0]            burst_high, burst_low;
  logic [3:0]            burst_num;
  logic [2:0]            pin_sel;
  int                    error_cnt, check_count;

  // Partner pin is routed to the timer under test only; the others see a quiet low input
  assign meas_pin_in = (src_pin === 1'h1) ? 6'h01 << pin_sel : 6'h00;

  timer_pwm_and_pulse_measure #(.PWM_PERIOD_TOP(TOP)) dut
  (
    .clock, .rst_n, .src_tick, .shared_start_wr, .shared_start_wdata, .second_start_wr, .second_start_wdata,
    .shared_start_rdata, .second_start_rdata, .pwm_mode_wr, .pwm_mode_wdata, .pwm_cnt_write, .pwm_irq_clr,
    .pwm_timer_mode_rdata, .pwm_timer_counter_rdata, .pwm_int_request_flag, .pwm_event_in,
    .pwm_output_pin, .meas_mode_wr, .meas_mode_wdata, .meas_cnt_wr, .meas_cnt_wdata, .meas_irq_clr,
    .meas_timer_mode_rdata, .meas_timer_counter_rdata, .meas_int_request_flag, .meas_pin_in
  );

  pulse_source source
  (
    .clock, .rst_n, .go(burst_go), .high_len(burst_high), .low_len(burst_low), .count(burst_num), .pin(src_pin)
  );

  // Clock
  initial
  begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  // ==========================================================
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic mode_reg_t mk(input logic [1:0] s, input logic one, input logic zero, input op_mode_t op);
    return '{s, 1'h0, 1'h0, one, zero, op};
  endfunction

  task automatic wr_start(input logic [7:0] sh, input logic [7:0] sec);
    shared_start_wdata = sh;
    second_start_wdata = sec;
    shared_start_wr = 1'h1;
    second_start_wr = 1'h1;
    cyc(1);
    shared_start_wr = 1'h0;
    second_start_wr = 1'h0;
    cyc(1);
  endtask

  task automatic pwm_mode(input mode_reg_t m);
    pwm_mode_wdata = m;
    pwm_mode_wr = 1'h1;
    cyc(1);
    pwm_mode_wr = 1'h0;
    cyc(1);
  endtask

  task automatic meas_mode(input int i, input mode_reg_t m);
    meas_mode_wdata = m;
    meas_mode_wr[i] = 1'h1;
    cyc(1);
    meas_mode_wr = 6'h00;
    cyc(1);
  endtask

  // Counter writes; the PWM timer's counter port carries its own strobe
  task automatic cnt_wr(input int i, input logic [15:0] v);
    meas_cnt_wdata = v;
    if (i < 0)
      pwm_cnt_write = '{1'h1, v};
    else
      meas_cnt_wr[i] = 1'h1;
    cyc(1);
    pwm_cnt_write.wr = 1'h0;
    meas_cnt_wr = 6'h00;
    cyc(1);
  endtask

  task automatic clr_irq(input int i);
    if (i < 0)
      pwm_irq_clr = 1'h1;
    else
      meas_irq_clr[i] = 1'h1;
    cyc(1);
    pwm_irq_clr = 1'h0;
    meas_irq_clr = 6'h00;
    cyc(1);
  endtask

  task automatic tick(input int s, input int n);
    repeat (n)
    begin
      src_tick[s] = 1'h1;
      cyc(1);
      src_tick[s] = 1'h0;
      cyc(1);
    end
  endtask

  // Go changes by non-blocking assignment, so the partner sees it one falling edge later
  task automatic burst(input logic [7:0] h, input logic [7:0] l, input logic [3:0] n);
    burst_high = h;
    burst_low = l;
    burst_num = n;
    burst_go <= 1'h1;
    cyc(2);
    burst_go <= 1'h0;
  endtask

  // Pin is polled on the rising edge, away from the partner's falling-edge updates
  task automatic wait_pin(input logic lvl);
    for (int k = 0; k <= 200; k++)
    begin
      @(posedge clock);
      if (src_pin === lvl)
        return;
    end
    error_cnt++;
    end_sim();
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_idle;
    chk(16'(shared_start_rdata), 16'h0000);
    tick(0, 3);
    chk(meas_timer_counter_rdata[0], 16'h0000);
    chk(16'(pwm_output_pin), 16'h0000);
    wr_start(8'h00, 8'hff);
    chk(16'(second_start_rdata), 16'h00e0);
    wr_start(8'h00, 8'h00);
  endtask

  task automatic s_timer;
    cnt_wr(0, 16'h0002);
    chk(meas_timer_counter_rdata[0], 16'h0002);
    wr_start(8'h20, 8'h00);
    chk(meas_timer_counter_rdata[0], 16'h0002);
    tick(0, 2);
    chk(meas_timer_counter_rdata[0], 16'h0000);
    // All ones stands for one cycle only, so look right after the reload edge
    src_tick[0] = 1'h1;
    cyc(1);
    src_tick[0] = 1'h0;
    chk(meas_timer_counter_rdata[0], 16'hffff);
    chk(16'(meas_int_request_flag[0]), 16'h0001);
    cyc(1);
    chk(meas_timer_counter_rdata[0], 16'h0002);
    wr_start(8'h00, 8'h00);
    clr_irq(0);
  endtask

  task automatic s_pwm_entry;
    op_mode_t prev [2] = '{OP_TIMER, OP_EVENT};
    // Timer is stopped for every mode write here
    foreach (prev[k])
    begin
      pwm_mode(mk(2'h0, 1'h0, 1'h0, prev[k]));
      clr_irq(-1);
      pwm_mode(mk(2'h0, 1'h0, 1'h0, OP_PWM));
      cyc(1);
      chk(16'(pwm_int_request_flag), 16'h0001);
      chk(16'(pwm_timer_mode_rdata), 16'h0003);
      clr_irq(-1);
      chk(16'(pwm_int_request_flag), 16'h0000);
    end
  endtask

  task automatic s_pwm_stop;
    cnt_wr(-1, 16'h0004);
    wr_start(8'h01, 8'h00);
    tick(0, 2);
    chk(16'(pwm_output_pin), 16'h0001);
    wr_start(8'h00, 8'h00);
    cyc(1);
    chk(16'(pwm_output_pin), 16'h0000);
    chk(16'(pwm_int_request_flag), 16'h0001);
    tick(0, 1);
    chk(pwm_timer_counter_rdata, TOP - 16'h0002);
    clr_irq(-1);
    wr_start(8'h01, 8'h00);
    tick(0, 6);
    clr_irq(-1);
    wr_start(8'h00, 8'h00);
    cyc(1);
    chk(16'(pwm_output_pin), 16'h0000);
    chk(16'(pwm_int_request_flag), 16'h0000);
    tick(0, 1);
    chk(pwm_timer_counter_rdata, TOP - 16'h0006);
    // Event mode on the PWM timer: one rising edge on its event pin, one count
    pwm_mode(mk(2'h0, 1'h0, 1'h0, OP_EVENT));
    cnt_wr(-1, 16'h0002);
    wr_start(8'h01, 8'h00);
    pwm_event_in = 1'h1;
    cyc(1);
    pwm_event_in = 1'h0;
    cyc(2);
    chk(pwm_timer_counter_rdata, 16'h0001);
    wr_start(8'h00, 8'h00);
  endtask

  task automatic s_event;
    pin_sel = 3'h1;
    meas_mode(1, mk(2'h0, 1'h0, 1'h1, OP_EVENT));
    cnt_wr(1, 16'h000a);
    wr_start(8'h40, 8'h00);
    burst(8'h02, 8'h02, 4'h3);
    cyc(16);
    chk(meas_timer_counter_rdata[1], 16'h0007);
    cyc(1);
    chk(meas_timer_counter_rdata[1], 16'h0007);
    wr_start(8'h00, 8'h00);
  endtask

  // Ticks run every cycle, so a measured span of p cycles reads p - 1
  task automatic s_period;
    pin_sel = 3'h2;
    meas_mode(2, mk(2'h0, 1'h0, 1'h1, OP_SPECIAL));
    src_tick = 4'h1;
    wr_start(8'h80, 8'h00);
    burst(8'h03, 8'h05, 4'h3);
    wait_pin(1'h1);
    cyc(3);
    chk(16'(meas_int_request_flag[2]), 16'h0000);
    wait_pin(1'h0);
    wait_pin(1'h1);
    cyc(3);
    chk(16'(meas_int_request_flag[2]), 16'h0001);
    chk(meas_timer_counter_rdata[2], 16'h0007);
    // Let the last pulse finish so the partner is idle for the next burst
    wait_pin(1'h1);
    wait_pin(1'h0);
    cyc(1);
    wr_start(8'h00, 8'h00);
  endtask

  task automatic s_width;
    pin_sel = 3'h3;
    meas_mode(3, mk(2'h0, 1'h1, 1'h0, OP_SPECIAL));
    wr_start(8'h00, 8'h20);
    burst(8'h03, 8'h06, 4'h2);
    wait_pin(1'h1);
    cyc(2);
    chk(16'(meas_int_request_flag[3]), 16'h0000);
    wait_pin(1'h0);
    cyc(2);
    chk(meas_timer_counter_rdata[3], 16'h0002);
    wait_pin(1'h1);
    cyc(2);
    chk(meas_timer_counter_rdata[3], 16'h0005);
    wr_start(8'h00, 8'h00);
    src_tick = 4'h0;
  endtask

  task automatic s_overflow;
    meas_mode(4, mk(2'h1, 1'h0, 1'h1, OP_SPECIAL));
    cnt_wr(4, 16'hfffe);
    // Timer 5 counts the same source, so its underflow tallies the overflow
    meas_mode(5, mk(2'h1, 1'h0, 1'h0, OP_TIMER));
    cnt_wr(5, 16'h0001);
    wr_start(8'h00, 8'hc0);
    tick(1, 2);
    chk(16'(meas_timer_mode_rdata[4].overflow_flag), 16'h0001);
    chk(16'(meas_int_request_flag[4]), 16'h0001);
    chk(16'(meas_int_request_flag[5]), 16'h0001);
    // Same fields rewritten with option two low; no tick has passed yet
    meas_mode(4, mk(2'h1, 1'h0, 1'h1, OP_SPECIAL));
    chk(16'(meas_timer_mode_rdata[4].overflow_flag), 16'h0001);
    tick(1, 1);
    meas_mode(4, mk(2'h1, 1'h0, 1'h1, OP_SPECIAL));
    chk(16'(meas_timer_mode_rdata[4].overflow_flag), 16'h0000);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {shared_start_wr, second_start_wr, pwm_mode_wr, pwm_irq_clr, burst_go, pwm_event_in} = '0;
    {src_tick, shared_start_wdata, second_start_wdata, pwm_mode_wdata, meas_mode_wdata} = '0;
    {pwm_cnt_write, meas_cnt_wdata, meas_mode_wr, meas_cnt_wr, meas_irq_clr} = '0;
    {burst_high, burst_low, burst_num, pin_sel} = '0;
    error_cnt = 0;
    check_count = 0;
    rst_n = 1'h0;
    cyc(16);
    rst_n = 1'h1;
    s_idle();
    s_timer();
    s_pwm_entry();
    s_pwm_stop();
    s_event();
    s_period();
    s_width();
    s_overflow();
    end_sim();
  end
endmodule
